/* verilog/dss_sequencer.sv */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module dss_sequencer import dss_pkg::*; #(
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input wire logic core_clk, // 100 MHz clock
	input wire logic rst, // Async reset, active high
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Write byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic enablePin, // Output enable pin
	input wire logic [5:0] strapCode, // Digitised strap resistor code
	input wire logic [11:0] trackRefMv, // tracking_ref_plus minus tracking_ref_minus, mV
	output dss_chan_out_type [1:0] chOut, // Per-channel stage enable and level
	output logic initDone // Initialisation finished
);
	logic [31:0] tickCnt, next_tickCnt;
	logic tick, next_tick;
	logic [7:0] initCnt, next_initCnt;
	logic next_initDone;
	logic enMeta, enSync;
	logic [5:0] strapMeta, strapSync, strapLatch, next_strapLatch;
	logic [11:0] refMeta, refSync;
	logic [2:0] ctrl, next_ctrl;
	dss_timing_type timing [2];
	dss_timing_type next_timing [2];
	logic [2:0] trackReg, next_trackReg;
	logic [11:0] target [2];
	logic [11:0] next_target [2];
	logic next_waitrequest;
	logic [31:0] next_readdata;
	logic [8:0] strapEntry;
	dss_cfg_type cfg [2];
	dss_chan_type chan [2];
	dss_chan_type next_chan [2];
	logic [11:0] scaledRef;
	logic [31:0] statusWord;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enMeta <= 1'b0;
			enSync <= 1'b0;
			strapMeta <= 6'h00;
			strapSync <= 6'h00;
			refMeta <= 12'h000;
			refSync <= 12'h000;
		end else begin
			enMeta <= enablePin;
			enSync <= enMeta;
			strapMeta <= strapCode;
			strapSync <= strapMeta;
			refMeta <= trackRefMv;
			refSync <= refMeta;
		end
	end

	// Millisecond tick and power-up initialisation
	always_comb begin
		next_tick = 1'b0;
		next_tickCnt = tickCnt + 32'h0000_0001;
		if (tickCnt >= 32'(TICK_COUNT - 1)) begin
			next_tickCnt = 32'h0000_0000;
			next_tick = 1'b1;
		end
		next_initCnt = initCnt;
		next_initDone = initDone;
		next_strapLatch = strapLatch;
		if (!initDone && tick) begin
			if (initCnt <= 8'h01) begin
				next_initDone = 1'b1;
				next_strapLatch = strapSync;
			end else begin
				next_initCnt = initCnt - 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tickCnt <= 32'h0000_0000;
			tick <= 1'b0;
			initCnt <= INIT_TIME_MS;
			initDone <= 1'b0;
			strapLatch <= 6'h00;
		end else begin
			tickCnt <= next_tickCnt;
			tick <= next_tick;
			initCnt <= next_initCnt;
			initDone <= next_initDone;
			strapLatch <= next_strapLatch;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	assign statusWord = {10'h000, strapLatch, 7'h00, chan[1].stageOn, chan[0].stageOn,
		chan[1].st, chan[0].st, initDone};

	// Register bus: once initDone is set, one wait cycle, then one cycle with waitrequest low
	always_comb begin
		logic [31:0] t;
		t = 32'h0000_0000;
		next_ctrl = ctrl;
		next_timing = timing;
		next_trackReg = trackReg;
		next_target = target;
		next_waitrequest = 1'b1;
		next_readdata = avs_readdata;
		if ((avs_read || avs_write) && avs_waitrequest && initDone) begin
			next_waitrequest = 1'b0;
			unique case (avs_address)
				ADDR_CTRL: next_readdata = {29'h0000_0000, ctrl};
				ADDR_TIMING1: next_readdata = timing[0];
				ADDR_TIMING2: next_readdata = timing[1];
				ADDR_TRACK: next_readdata = {29'h0000_0000, trackReg};
				ADDR_TARGET1: next_readdata = {20'h0_0000, target[0]};
				ADDR_TARGET2: next_readdata = {20'h0_0000, target[1]};
				ADDR_STATUS: next_readdata = statusWord;
				default: next_readdata = 32'h0000_0000;
			endcase
		end
		if (avs_write && !avs_waitrequest) begin
			unique case (avs_address)
				ADDR_CTRL: begin
					t = merge({29'h0000_0000, ctrl}, avs_writedata, avs_byteenable);
					next_ctrl = t[2:0];
				end
				ADDR_TIMING1: next_timing[0] = merge(timing[0], avs_writedata, avs_byteenable);
				ADDR_TIMING2: next_timing[1] = merge(timing[1], avs_writedata, avs_byteenable);
				ADDR_TRACK: begin
					t = merge({29'h0000_0000, trackReg}, avs_writedata, avs_byteenable);
					next_trackReg = t[2:0];
				end
				ADDR_TARGET1: begin
					t = merge({20'h0_0000, target[0]}, avs_writedata, avs_byteenable);
					next_target[0] = t[11:0];
				end
				ADDR_TARGET2: begin
					t = merge({20'h0_0000, target[1]}, avs_writedata, avs_byteenable);
					next_target[1] = t[11:0];
				end
				default: t = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl <= 3'h0;
			timing[0] <= TIMING_RST;
			timing[1] <= TIMING_RST;
			trackReg <= 3'h0;
			target[0] <= TARGET_RST;
			target[1] <= TARGET_RST;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			timing <= next_timing;
			trackReg <= next_trackReg;
			target <= next_target;
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
		end
	end

	function automatic logic [7:0] strapDly(input logic [1:0] code);
		return (code == 2'h0) ? STRAP_DLY0_MS : (code == 2'h1) ? STRAP_DLY1_MS : STRAP_DLY2_MS;
	endfunction : strapDly

	// Configuration: ctrl[0] selects bus settings over the strap
	assign strapEntry = (strapLatch < 6'(STRAP_CODES)) ? STRAP_TABLE[strapLatch] : 9'h000;
	assign scaledRef = (ctrl[0] ? trackReg[2] : strapEntry[8]) ? {1'b0, refSync[11:1]} : refSync;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cfg[i].target = target[i];
			cfg[i].immOff = ctrl[1 + i];
			if (ctrl[0]) begin
				cfg[i].tm = timing[i];
				cfg[i].track = trackReg[i] && !(i == 0 && trackReg[1]);
			end else begin
				cfg[i].tm.onDly = strapDly(strapEntry[2*i +: 2]);
				cfg[i].tm.offDly = strapDly(strapEntry[2*i +: 2]);
				cfg[i].tm.onRamp = strapEntry[4 + i] ? STRAP_RAMP1_MS : STRAP_RAMP0_MS;
				cfg[i].tm.offRamp = strapEntry[4 + i] ? STRAP_RAMP1_MS : STRAP_RAMP0_MS;
				cfg[i].track = strapEntry[7:6] == 2'(i + 1);
			end
		end
	end

	// Independent sequencing machine per channel
	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic [11:0] onStep, offStep, trackLevel;
		assign onStep = (cfg[c].tm.onRamp == 8'h00) ? cfg[c].target :
			cfg[c].target / {4'h0, cfg[c].tm.onRamp};
		assign offStep = (cfg[c].tm.offRamp == 8'h00) ? cfg[c].target :
			cfg[c].target / {4'h0, cfg[c].tm.offRamp};
		assign trackLevel = (scaledRef < TRACK_MIN_MV) ? 12'h000 :
			(scaledRef > cfg[c].target) ? cfg[c].target : scaledRef;

		always_comb begin
			next_chan[c] = chan[c];
			if (tick && chan[c].cnt != 8'h00) begin
				next_chan[c].cnt = chan[c].cnt - 8'h01;
			end
			unique case (chan[c].st)
				ST_OFF: begin
					next_chan[c].level = 12'h000;
					next_chan[c].stageOn = 1'b0;
					if (initDone && enSync && cfg[c].track) begin
						next_chan[c].st = ST_TRACK;
					end else if (initDone && enSync) begin
						next_chan[c].st = ST_ON_DLY;
						next_chan[c].cnt = (cfg[c].tm.onDly == 8'h00) ? ZERO_DLY_MS :
							cfg[c].tm.onDly;
					end
				end
				ST_ON_DLY: begin
					if (!enSync) begin
						next_chan[c].st = ST_OFF;
					end else if (chan[c].cnt == 8'h00) begin
						next_chan[c].st = ST_RISE;
						next_chan[c].stageOn = 1'b1;
						next_chan[c].cnt = cfg[c].tm.onRamp;
					end
				end
				ST_RISE: begin
					if (!enSync) begin
						next_chan[c].st = ST_OFF_DLY;
						next_chan[c].cnt = cfg[c].tm.offDly;
					end else if (chan[c].cnt == 8'h00) begin
						next_chan[c].level = cfg[c].target;
						next_chan[c].st = ST_ON;
					end else if (tick) begin
						next_chan[c].level = (cfg[c].target - chan[c].level > onStep) ?
							chan[c].level + onStep : cfg[c].target;
					end
				end
				ST_ON: begin
					next_chan[c].level = cfg[c].target;
					if (!enSync) begin
						next_chan[c].st = ST_OFF_DLY;
						next_chan[c].cnt = cfg[c].tm.offDly;
					end
				end
				ST_OFF_DLY: begin
					if (enSync) begin
						next_chan[c].st = ST_RISE;
						next_chan[c].cnt = cfg[c].tm.onRamp;
					end else if (chan[c].cnt == 8'h00) begin
						if (cfg[c].immOff || cfg[c].tm.offRamp == 8'h00) begin
							next_chan[c].st = ST_OFF;
							next_chan[c].stageOn = 1'b0;
							next_chan[c].level = 12'h000;
						end else begin
							next_chan[c].st = ST_FALL;
							next_chan[c].cnt = cfg[c].tm.offRamp;
						end
					end
				end
				ST_FALL: begin
					if (chan[c].cnt == 8'h00 || chan[c].level == 12'h000) begin
						next_chan[c].st = ST_OFF;
						next_chan[c].stageOn = 1'b0;
						next_chan[c].level = 12'h000;
					end else if (tick) begin
						next_chan[c].level = (chan[c].level > offStep) ?
							chan[c].level - offStep : 12'h000;
					end
				end
				ST_TRACK: begin
					next_chan[c].level = trackLevel;
					next_chan[c].stageOn = 1'b1;
					if (!enSync && trackLevel == 12'h000) begin
						next_chan[c].st = ST_OFF;
						next_chan[c].stageOn = 1'b0;
					end
				end
				default: next_chan[c].st = ST_OFF;
			endcase
		end

		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				chan[c] <= '{st: ST_OFF, cnt: 8'h00, level: 12'h000, stageOn: 1'b0};
			end else begin
				chan[c] <= next_chan[c];
			end
		end

		assign chOut[c] = '{stageOn: chan[c].stageOn, level: chan[c].level};

		AST_INIT_HOLD: assert property (@(posedge core_clk) disable iff (rst)
			!initDone |=> chan[c].st == ST_OFF) else $error("Channel left off before init");
		sequence s_zero_dly_start;
			chan[c].st == ST_OFF ##1 chan[c].st == ST_ON_DLY && cfg[c].tm.onDly == 8'h00;
		endsequence
		AST_ZERO_DELAY: assert property (@(posedge core_clk) disable iff (rst)
			s_zero_dly_start |-> chan[c].cnt == ZERO_DLY_MS)
			else $error("Zero delay not held 2 ms");
		AST_DELAY_TO_RISE: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_ON_DLY && chan[c].cnt == 8'h00 && enSync |=> chan[c].st == ST_RISE)
			else $error("Delay expiry did not start ramp");
		AST_RAMP_ZERO: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_RISE && cfg[c].tm.onRamp == 8'h00 && enSync
			&& $stable(cfg[c].target) |=> chan[c].level == cfg[c].target)
			else $error("Zero ramp did not jump to target");
		AST_IMM_OFF: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_OFF_DLY && chan[c].cnt == 8'h00 && !enSync && cfg[c].immOff
			|=> !chan[c].stageOn && chan[c].level == 12'h000)
			else $error("Immediate off not applied");
		AST_TRACK_NO_DELAY: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_OFF && initDone && enSync && cfg[c].track
			|=> chan[c].st == ST_TRACK)
			else $error("Tracking channel used its delay");
		AST_TRACK_CAP: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_TRACK && $stable(cfg[c].target) |=> chan[c].level <= cfg[c].target)
			else $error("Tracking passed target");
		AST_TRACK_MIN: assert property (@(posedge core_clk) disable iff (rst)
			chan[c].st == ST_TRACK && scaledRef < TRACK_MIN_MV |=> chan[c].level == 12'h000)
			else $error("Tracked below minimum level");
	end

	AST_BUS_INIT: assert property (@(posedge core_clk) disable iff (rst)
		!initDone |-> avs_waitrequest) else $error("Bus answered before init");
	AST_ONE_TRACK: assert property (@(posedge core_clk) disable iff (rst)
		!(cfg[0].track && cfg[1].track)) else $error("Both channels tracking");
	AST_TICK_GAP: assert property (@(posedge core_clk) disable iff (rst)
		tick |=> !tick) else $error("Tick lasted more than one cycle");

endmodule : dss_sequencer

/* verilog/dss_pkg.sv */
package dss_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1_000_000;
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam logic [7:0] INIT_TIME_MS = 8'h41;
	localparam logic [7:0] ZERO_DLY_MS = 8'h02;
	localparam logic [7:0] STRAP_DLY0_MS = 8'h05;
	localparam logic [7:0] STRAP_DLY1_MS = 8'h0A;
	localparam logic [7:0] STRAP_DLY2_MS = 8'h14;
	localparam logic [7:0] STRAP_RAMP0_MS = 8'h02;
	localparam logic [7:0] STRAP_RAMP1_MS = 8'h05;
	localparam logic [11:0] TRACK_MIN_MV = 12'h0C8;
	localparam logic [11:0] TARGET_RST = 12'h3E8;
	localparam logic [31:0] TIMING_RST = 32'h0205_0205;
	localparam int STRAP_CODES = 34;
	// Strap entry: [8] half ratio, [7:6] tracking channel, [5] ch2 ramp,
	// [4] ch1 ramp, [3:2] ch2 delay, [1:0] ch1 delay
	localparam logic [8:0] STRAP_TABLE [STRAP_CODES] = '{
		9'h000, 9'h020, 9'h010, 9'h030, 9'h004, 9'h024, 9'h014, 9'h034,
		9'h001, 9'h021, 9'h011, 9'h031, 9'h002, 9'h032, 9'h008, 9'h028,
		9'h018, 9'h038, 9'h080, 9'h180, 9'h090, 9'h190, 9'h081, 9'h181,
		9'h091, 9'h191, 9'h040, 9'h140, 9'h060, 9'h160, 9'h044, 9'h144,
		9'h064, 9'h164};
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_TIMING1 = 5'h04;
	localparam logic [4:0] ADDR_TIMING2 = 5'h08;
	localparam logic [4:0] ADDR_TRACK = 5'h0C;
	localparam logic [4:0] ADDR_TARGET1 = 5'h10;
	localparam logic [4:0] ADDR_TARGET2 = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ON_DLY = 3'h1,
		ST_RISE = 3'h3,
		ST_ON = 3'h2,
		ST_OFF_DLY = 3'h6,
		ST_FALL = 3'h7,
		ST_TRACK = 3'h5
	} dss_state_type;
	typedef struct packed {
		logic [7:0] offRamp;
		logic [7:0] offDly;
		logic [7:0] onRamp;
		logic [7:0] onDly;
	} dss_timing_type;
	typedef struct packed {
		dss_timing_type tm;
		logic [11:0] target;
		logic immOff;
		logic track;
	} dss_cfg_type;
	typedef struct packed {
		logic stageOn;
		logic [11:0] level;
	} dss_chan_out_type;
	typedef struct packed {
		dss_state_type st;
		logic [7:0] cnt;
		logic [11:0] level;
		logic stageOn;
	} dss_chan_type;
endpackage : dss_pkg

/* verification/dss_track_source.sv */
`timescale 1ns/10ps
module dss_track_source #(
	parameter int STEP_MV = 50
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Async reset, active high
	input wire logic [11:0] goalMv, // Level the reference heads for
	output logic [11:0] trackRefMv // Slew-limited tracking reference
);
	logic [11:0] next_trackRefMv;
	// Step at most STEP_MV per cycle, i.e. 1 V per ms at the bench tick
	always_comb begin
		next_trackRefMv = goalMv;
		if (goalMv > trackRefMv + 12'(STEP_MV)) begin
			next_trackRefMv = trackRefMv + 12'(STEP_MV);
		end else if (trackRefMv > goalMv + 12'(STEP_MV)) begin
			next_trackRefMv = trackRefMv - 12'(STEP_MV);
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trackRefMv <= 12'h000;
		end else begin
			trackRefMv <= next_trackRefMv;
		end
	end
endmodule : dss_track_source

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench import dss_pkg::*;;
	localparam int T = 20;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avsAddress = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0000_0000;
	logic [3:0] avsByteenable = 4'hF;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic enablePin = 1'b0;
	logic [5:0] strapCode = 6'h07;
	logic [11:0] goalMv = 12'h000;
	logic [11:0] trackRefMv;
	dss_chan_out_type [1:0] chOut;
	logic initDone;
	logic [31:0] rd;
	int cyc = 0;
	int t0 = 0;
	int t = 0;
	int n_mismatch = 0;
	int cmp_count = 0;

	dss_sequencer #(.TICK_COUNT(T)) u_dut (
		.core_clk(core_clk), .rst(rst), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
		.avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest), .enablePin(enablePin), .strapCode(strapCode),
		.trackRefMv(trackRefMv), .chOut(chOut), .initDone(initDone)
	);
	dss_track_source #(.STEP_MV(1000 / T)) u_ref (
		.core_clk(core_clk), .rst(rst), .goalMv(goalMv), .trackRefMv(trackRefMv)
	);

	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic timeout(string what);
		n_mismatch++;
		$display("[FAIL] %s expected completion seen timeout", what);
		print_verdict();
	endtask : timeout

	task automatic check_eq(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_eq

	task automatic check_in(string what, int lo, int hi, int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_in

	// One Avalon access; the request stands until waitrequest is seen low
	task automatic bus(logic wr, logic [4:0] addr, logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge core_clk);
		avsAddress <= addr;
		avsWritedata <= wdata;
		avsWrite <= wr;
		avsRead <= ~wr;
		do begin
			@(posedge core_clk);
			n++;
			if (n > 80 * T) timeout("bus");
		end while (avsWaitrequest !== 1'b0);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask : bus

	task automatic drive(logic en, logic [11:0] goal);
		@(posedge core_clk);
		enablePin <= en;
		goalMv <= goal;
		t0 = cyc;
		@(negedge core_clk);
	endtask : drive

	// Counts as a comparison; returns cycles since the last drive
	task automatic wait_level(int ch, logic [11:0] lvl, int lim);
		int n;
		n = 0;
		cmp_count++;
		while (chOut[ch].level !== lvl) begin
			@(negedge core_clk);
			n++;
			if (n > lim) timeout("channel level");
		end
		t = cyc - t0;
	endtask : wait_level

	task automatic wait_ref();
		int n;
		n = 0;
		while (trackRefMv !== goalMv) begin
			@(negedge core_clk);
			n++;
			if (n > 200) timeout("reference");
		end
	endtask : wait_ref

	task automatic sc_init();
		check_eq("initDone at reset", 32'h0000_0000, 32'(initDone));
		check_eq("waitrequest at reset", 32'h0000_0001, 32'(avsWaitrequest));
		check_eq("outputs at reset", 32'h0000_0000, 32'(chOut));
		t0 = cyc;
		bus(1'b0, ADDR_STATUS, 32'h0000_0000);
		check_in("init cycles", 60 * T, 70 * T + 10, cyc - t0);
		check_eq("status init", 32'h0000_0001, 32'(rd[0]));
		check_eq("latched strap", 32'h0000_0007, 32'(rd[21:16]));
		bus(1'b0, ADDR_TIMING1, 32'h0000_0000);
		check_eq("timing1 reset", 32'h0205_0205, rd);
		bus(1'b0, 5'h1C, 32'h0000_0000);
		check_eq("unmapped read", 32'h0000_0000, rd);
		avsByteenable <= 4'h2;
		bus(1'b1, ADDR_TIMING1, 32'hFFFF_FFFF);
		avsByteenable <= 4'hF;
		bus(1'b0, ADDR_TIMING1, 32'h0000_0000);
		check_eq("timing1 lane merge", 32'h0205_FF05, rd);
	endtask : sc_init

	// Strap 7: ch1 5 ms, ch2 10 ms delay, both 5 ms ramps, on and off
	task automatic sc_strap();
		drive(1'b1, 12'h000);
		wait_level(0, TARGET_RST, 400);
		check_in("ch1 on time", 9 * T - 5, 10 * T + 10, t);
		check_eq("ch1 stage on", 32'h0000_0001, 32'(chOut[0].stageOn));
		wait_level(1, TARGET_RST, 400);
		check_in("ch2 on time", 14 * T - 5, 15 * T + 10, t);
		drive(1'b0, 12'h000);
		wait_level(0, 12'h000, 400);
		check_in("ch1 off time", 9 * T - 5, 10 * T + 10, t);
		wait_level(1, 12'h000, 400);
		check_in("ch2 off time", 14 * T - 5, 15 * T + 10, t);
		// Stage drops one cycle after the fall reaches zero
		@(negedge core_clk);
		check_eq("ch2 stage off", 32'h0000_0000, 32'(chOut[1].stageOn));
	endtask : sc_strap

	task automatic sc_bus();
		bus(1'b1, ADDR_TIMING1, 32'h0301_0000);
		bus(1'b1, ADDR_TIMING2, 32'h0302_0000);
		bus(1'b1, ADDR_TARGET1, 32'h0000_01F4);
		bus(1'b1, ADDR_CTRL, 32'h0000_0003);
		bus(1'b0, ADDR_TIMING2, 32'h0000_0000);
		check_eq("timing2 readback", 32'h0302_0000, rd);
		drive(1'b1, 12'h000);
		wait_level(0, 12'h1F4, 200);
		check_in("zero delay and ramp", T, 2 * T + 10, t);
		wait_level(1, TARGET_RST, 200);
		check_in("ch2 zero delay", T, 2 * T + 10, t);
		drive(1'b0, 12'h000);
		wait_level(0, 12'h000, 200);
		check_in("immediate off", 0, T + 10, t);
		check_eq("ch1 stage off", 32'h0000_0000, 32'(chOut[0].stageOn));
		wait_level(1, 12'h000, 400);
		check_in("ch2 bus off time", 4 * T - 5, 5 * T + 10, t);
	endtask : sc_bus

	task automatic sc_track();
		bus(1'b1, ADDR_TARGET2, 32'h0000_01F4);
		bus(1'b1, ADDR_TRACK, 32'h0000_0006);
		drive(1'b1, 12'h000);
		drive(1'b1, 12'h320);
		wait_level(1, 12'h190, 80);
		check_in("track ignores delay", 0, 40, t);
		drive(1'b1, 12'h7D0);
		wait_ref();
		check_eq("ch2 capped", 32'h0000_01F4, 32'(chOut[1].level));
		drive(1'b1, 12'h12C);
		wait_level(1, 12'h000, 100);
		drive(1'b0, 12'h12C);
		wait_level(0, 12'h000, 100);
		bus(1'b1, ADDR_TRACK, 32'h0000_0003);
		drive(1'b1, 12'h12C);
		drive(1'b1, 12'h1C2);
		wait_level(1, 12'h1C2, 100);
		wait_level(0, 12'h1F4, 100);
		check_eq("ch1 not tracking", 32'h0000_01F4, 32'(chOut[0].level));
		drive(1'b0, 12'h000);
		wait_level(1, 12'h000, 100);
	endtask : sc_track

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		sc_init();
		sc_strap();
		sc_bus();
		sc_track();
		print_verdict();
	end
endmodule : testbench
